/* File: verilog/rtcbk_core.v */
// Real-time clock with prescaler, alarm, calibration output and backup store
`timescale 1ns/10ps
`include "rtcbk_defines.vh"

module rtcbk_core #(
   parameter PRESC_W = 20,
   parameter FAST_DIV = `RTCBK_FAST_DIV,
   parameter CAL_HALF = `RTCBK_CAL_HALF
) (
   // Clock, resets, enable
   input wire clk_in,
   input wire external_reset_pin_in,
   input wire bkp_external_reset_pin_in,
   input wire clk_en_in,
   // Clock source ticks, one cycle per source period
   input wire xtal_tick_in,
   input wire lprc_tick_in,
   input wire fast_external_clock_tick_in,
   // Low-power state
   input wire standby_in,
   // AXI4-Lite write address
   input wire awvalid_in,
   input wire [7:0] awaddr_in,
   output wire awready_out,
   // AXI4-Lite write data
   input wire wvalid_in,
   input wire [31:0] wdata_in,
   input wire [3:0] wstrb_in,
   output wire wready_out,
   // AXI4-Lite write response
   output wire bvalid_out,
   output wire [1:0] bresp_out,
   input wire bready_in,
   // AXI4-Lite read address
   input wire arvalid_in,
   input wire [7:0] araddr_in,
   output wire arready_out,
   // AXI4-Lite read data
   output wire rvalid_out,
   output wire [31:0] rdata_out,
   output wire [1:0] rresp_out,
   input wire rready_in,
   // Events and pins
   output wire irq_out,
   output wire alarm_event_out,
   output wire standby_wake_out,
   output wire cal_out
);

   localparam FD_W = 7;
   localparam CD_W = 5;
   // Divider end counts, cut to the counter widths
   localparam integer FD_LAST_I = FAST_DIV - 1;
   localparam integer CD_LAST_I = CAL_HALF - 1;
   localparam [FD_W-1:0] FD_LAST = FD_LAST_I[FD_W-1:0];
   localparam [CD_W-1:0] CD_LAST = CD_LAST_I[CD_W-1:0];

   // Bus side state, lost on system reset
   reg awready_ff, wready_ff, arready_ff;
   reg aw_full_ff, w_full_ff;
   reg [5:0] waddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   reg bvalid_ff, rvalid_ff;
   reg [1:0] bresp_ff, rresp_ff;
   reg [31:0] rdata_ff;
   reg [1:0] stat_ff, mask_ff;
   reg irq_ff, alarm_ev_ff, wake_ff;
   // Backup domain state
   reg [2:0] ctrl_ff;
   reg [PRESC_W-1:0] reload_ff, presc_ff;
   reg [31:0] count_ff, cmp_ff;
   reg [15:0] bkp_ff [0:`RTCBK_BKP_NUM-1];
   reg [FD_W-1:0] fdiv_ff;
   reg fast_tick_ff;
   reg [CD_W-1:0] cdiv_ff;
   reg cal_ff;
   integer i;

   // Merge write data into a word under the byte strobes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] new_val;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[8*k +: 8] = new_val[8*k +: 8];
            end
         end
      end
   endfunction

   // Address decode: mapped word indices
   function mapped;
      input [5:0] idx;
      begin
         mapped = (idx <= `RTCBK_IDX_CMP) ||
            ((idx >= `RTCBK_IDX_BKP0) && (idx < `RTCBK_IDX_BKP0 + `RTCBK_BKP_NUM));
      end
   endfunction

   // Handshakes and write commit
   wire aw_hs = awvalid_in & awready_ff;
   wire w_hs = wvalid_in & wready_ff;
   wire ar_hs = arvalid_in & arready_ff;
   wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire wr_hit = do_write & mapped(waddr_ff);
   wire [5:0] rd_idx = araddr_in[7:2];
   wire [3:0] bkp_wsel = waddr_ff[3:0] - 4'h8;
   wire [3:0] bkp_rsel = rd_idx[3:0] - 4'h8;
   // Byte-merged write words, cut to each register's width on use
   wire [31:0] ctrl_mg = merge({29'h00000000, ctrl_ff}, wdata_ff, wstrb_ff);
   wire [31:0] reload_mg = merge({{(32-PRESC_W){1'b0}}, reload_ff}, wdata_ff, wstrb_ff);
   wire [31:0] mask_mg = merge({30'h00000000, mask_ff}, wdata_ff, wstrb_ff);
   wire [31:0] bkp_mg = merge({16'h0000, bkp_ff[bkp_wsel]}, wdata_ff, wstrb_ff);
   wire nxt_aw_full = (aw_full_ff | aw_hs) & ~do_write;
   wire nxt_w_full = (w_full_ff | w_hs) & ~do_write;
   wire nxt_bvalid = do_write | (bvalid_ff & ~bready_in);
   wire nxt_rvalid = ar_hs | (rvalid_ff & ~rready_in);

   // Source selection and fast clock divide by 128
   reg src_tick;
   always @* begin
      case (ctrl_ff[`RTCBK_CTRL_SEL_HI:`RTCBK_CTRL_SEL_LO])
         `RTCBK_SRC_XTAL: src_tick = xtal_tick_in;
         `RTCBK_SRC_LPRC: src_tick = lprc_tick_in;
         `RTCBK_SRC_FAST: src_tick = fast_tick_ff;
         default: src_tick = 1'b0;
      endcase
   end

   // Time-base tick at prescaler underflow
   wire tb_tick = src_tick & (presc_ff == {PRESC_W{1'b0}});
   wire [31:0] nxt_count_inc = count_ff + 32'h00000001;
   wire alarm_hit = tb_tick & (nxt_count_inc == cmp_ff);
   wire [1:0] ev_set = {alarm_hit, tb_tick};

   // Read data selection
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (rd_idx)
         `RTCBK_IDX_CTRL: rd_mux[2:0] = ctrl_ff;
         `RTCBK_IDX_STAT: rd_mux[1:0] = stat_ff;
         `RTCBK_IDX_MASK: rd_mux[1:0] = mask_ff;
         `RTCBK_IDX_RELOAD: rd_mux[PRESC_W-1:0] = reload_ff;
         `RTCBK_IDX_PRESC: rd_mux[PRESC_W-1:0] = presc_ff;
         `RTCBK_IDX_COUNT: rd_mux = count_ff;
         `RTCBK_IDX_CMP: rd_mux = cmp_ff;
         default: begin
            if (mapped(rd_idx)) begin
               rd_mux[15:0] = bkp_ff[bkp_rsel];
            end
         end
      endcase
   end

   // Read of status clears it; a new event in the same cycle wins
   wire rd_stat = ar_hs & (rd_idx == `RTCBK_IDX_STAT);
   wire [1:0] nxt_stat = (stat_ff & ~{2{rd_stat}}) | ev_set;
   wire [1:0] nxt_mask = (wr_hit && waddr_ff == `RTCBK_IDX_MASK) ?
      mask_mg[1:0] : mask_ff;

   // Bus slave and interrupt state, system reset domain
   always @(posedge clk_in or negedge external_reset_pin_in) begin
      if (!external_reset_pin_in) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         arready_ff <= 1'b0;
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         waddr_ff <= 6'h00;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RTCBK_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= `RTCBK_RESP_OKAY;
         rdata_ff <= 32'h00000000;
         stat_ff <= 2'h0;
         mask_ff <= 2'h0;
         irq_ff <= 1'b0;
         alarm_ev_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else if (clk_en_in) begin
         awready_ff <= ~nxt_aw_full;
         wready_ff <= ~nxt_w_full;
         arready_ff <= ~nxt_rvalid;
         aw_full_ff <= nxt_aw_full;
         w_full_ff <= nxt_w_full;
         if (aw_hs) begin
            waddr_ff <= awaddr_in[7:2];
         end
         if (w_hs) begin
            wdata_ff <= wdata_in;
            wstrb_ff <= wstrb_in;
         end
         bvalid_ff <= nxt_bvalid;
         if (do_write) begin
            bresp_ff <= mapped(waddr_ff) ? `RTCBK_RESP_OKAY : `RTCBK_RESP_SLVERR;
         end
         rvalid_ff <= nxt_rvalid;
         if (ar_hs) begin
            rdata_ff <= rd_mux;
            rresp_ff <= mapped(rd_idx) ? `RTCBK_RESP_OKAY : `RTCBK_RESP_SLVERR;
         end
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff <= |(nxt_stat & nxt_mask);
         alarm_ev_ff <= alarm_hit;
         wake_ff <= alarm_hit & standby_in;
      end
   end

   // Time base, counters and backup store; only the backup reset clears them
   always @(posedge clk_in or negedge bkp_external_reset_pin_in) begin
      if (!bkp_external_reset_pin_in) begin
         ctrl_ff <= `RTCBK_RST_CTRL;
         reload_ff <= `RTCBK_RST_RELOAD;
         presc_ff <= `RTCBK_RST_RELOAD;
         count_ff <= 32'h00000000;
         cmp_ff <= `RTCBK_RST_CMP;
         fdiv_ff <= {FD_W{1'b0}};
         fast_tick_ff <= 1'b0;
         cdiv_ff <= {CD_W{1'b0}};
         cal_ff <= 1'b0;
         for (i = 0; i < `RTCBK_BKP_NUM; i = i + 1) begin
            bkp_ff[i] <= 16'h0000;
         end
      end else if (clk_en_in) begin
         // Fast clock divider
         fast_tick_ff <= fast_external_clock_tick_in & (fdiv_ff == FD_LAST);
         if (fast_external_clock_tick_in) begin
            fdiv_ff <= (fdiv_ff == FD_LAST) ? {FD_W{1'b0}} : fdiv_ff + 1'b1;
         end
         // Prescaler down count and reload
         if (src_tick) begin
            presc_ff <= tb_tick ? reload_ff : presc_ff - 1'b1;
         end
         // Calibration square wave, source divided by 64
         if (!ctrl_ff[`RTCBK_CTRL_CAL]) begin
            cdiv_ff <= {CD_W{1'b0}};
            cal_ff <= 1'b0;
         end else if (src_tick) begin
            cdiv_ff <= (cdiv_ff == CD_LAST) ? {CD_W{1'b0}} : cdiv_ff + 1'b1;
            if (cdiv_ff == CD_LAST) begin
               cal_ff <= ~cal_ff;
            end
         end
         // Counter: software write wins over tick
         if (wr_hit && waddr_ff == `RTCBK_IDX_COUNT) begin
            count_ff <= merge(count_ff, wdata_ff, wstrb_ff);
         end else if (tb_tick) begin
            count_ff <= nxt_count_inc;
         end
         // Configuration writes
         if (wr_hit) begin
            case (waddr_ff)
               `RTCBK_IDX_CTRL: ctrl_ff <= ctrl_mg[2:0];
               `RTCBK_IDX_RELOAD: reload_ff <= reload_mg[PRESC_W-1:0];
               `RTCBK_IDX_CMP: cmp_ff <= merge(cmp_ff, wdata_ff, wstrb_ff);
               default: begin
                  if (waddr_ff >= `RTCBK_IDX_BKP0) begin
                     bkp_ff[bkp_wsel] <= bkp_mg[15:0];
                  end
               end
            endcase
         end
      end
   end

   // Outputs straight from flip-flops
   assign awready_out = awready_ff;
   assign wready_out = wready_ff;
   assign arready_out = arready_ff;
   assign bvalid_out = bvalid_ff;
   assign bresp_out = bresp_ff;
   assign rvalid_out = rvalid_ff;
   assign rdata_out = rdata_ff;
   assign rresp_out = rresp_ff;
   assign irq_out = irq_ff;
   assign alarm_event_out = alarm_ev_ff;
   assign standby_wake_out = wake_ff;
   assign cal_out = cal_ff;

endmodule

/* File: verilog/rtcbk_defines.vh */
// Offsets, field positions, reset values and divider counts of the clock block
`ifndef RTCBK_DEFINES_VH
`define RTCBK_DEFINES_VH
// Word indices of the registers (byte address = 4 * index)
`define RTCBK_IDX_CTRL 6'h00
`define RTCBK_IDX_STAT 6'h01
`define RTCBK_IDX_MASK 6'h02
`define RTCBK_IDX_RELOAD 6'h03
`define RTCBK_IDX_PRESC 6'h04
`define RTCBK_IDX_COUNT 6'h05
`define RTCBK_IDX_CMP 6'h06
`define RTCBK_IDX_BKP0 6'h08
`define RTCBK_BKP_NUM 10
// Control fields
`define RTCBK_CTRL_SEL_LO 0
`define RTCBK_CTRL_SEL_HI 1
`define RTCBK_CTRL_CAL 2
// Clock source codes
`define RTCBK_SRC_XTAL 2'h0
`define RTCBK_SRC_LPRC 2'h1
`define RTCBK_SRC_FAST 2'h2
`define RTCBK_SRC_OFF 2'h3
// Status and mask fields
`define RTCBK_ST_PER 0
`define RTCBK_ST_ALM 1
// Reset values
`define RTCBK_RST_CTRL 3'h0
`define RTCBK_RST_RELOAD 20'h07FFF
`define RTCBK_RST_CMP 32'hFFFFFFFF
// Fast clock divide ratio and calibration half period in source ticks
`define RTCBK_FAST_DIV 128
`define RTCBK_CAL_HALF 32
// Bus responses
`define RTCBK_RESP_OKAY 2'h0
`define RTCBK_RESP_SLVERR 2'h2
`endif

/* File: testbench/rtcbk_props.sv */
// Port checker for the clock block, bound to the core
`timescale 1ns/10ps
module rtcbk_props (
   // Clock and reset
   input wire clk_in,
   input wire external_reset_pin_in,
   // Bus handshakes
   input wire awvalid_in,
   input wire awready_out,
   input wire wvalid_in,
   input wire wready_out,
   input wire bvalid_out,
   input wire [1:0] bresp_out,
   input wire bready_in,
   input wire arvalid_in,
   input wire arready_out,
   input wire rvalid_out,
   input wire [31:0] rdata_out,
   input wire rready_in,
   // Events and pins
   input wire alarm_event_out,
   input wire standby_wake_out,
   input wire cal_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!external_reset_pin_in);
   // Write answer two edges after a joint handshake
   a_b_latency: assert property (awvalid_in && awready_out && wvalid_in && wready_out
      |-> ##2 bvalid_out) else $error("write answer late");
   // Read answer one edge after handshake
   a_r_latency: assert property (arvalid_in && arready_out |=> rvalid_out)
      else $error("read answer late");
   // Answers stand until accepted
   a_b_hold: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
      else $error("write answer dropped");
   a_r_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
      else $error("read answer dropped");
   // No new read while one is pending
   a_ar_refuse: assert property (rvalid_out |-> !arready_out)
      else $error("read taken while pending");
   // Alarm event and wake are single pulses
   a_alarm_pulse: assert property (alarm_event_out |=> !alarm_event_out)
      else $error("alarm pulse too long");
   a_wake_pair: assert property (standby_wake_out |-> alarm_event_out)
      else $error("wake without alarm");
   // Calibration wave holds for eight edges after each toggle
   a_cal_stable: assert property ($changed(cal_out) |=> $stable(cal_out) [*8])
      else $error("calibration output glitch");
endmodule
bind rtcbk_core rtcbk_props i_props (.*);

/* File: testbench/rtcbk_core_tb.sv */
// Bus-level self-checking bench for the clock block
`timescale 1ns/10ps
`include "rtcbk_defines.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   $display("Error %s expected %h seen %h", n, e, s); num_errors++; end end
module rtcbk_core_tb;
   reg clk_in = 0, external_reset_pin_in = 0, bkp_external_reset_pin_in = 0, clk_en_in = 1, standby_in = 0;
   reg xtal_tick_in = 0, lprc_tick_in = 0, fast_external_clock_tick_in = 0;
   reg awvalid_in = 0, wvalid_in = 0, bready_in = 0, arvalid_in = 0, rready_in = 0;
   reg [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
   reg [31:0] wdata_in = 32'h0;
   reg [3:0] wstrb_in = 4'hF;
   wire awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   wire irq_out, alarm_event_out, standby_wake_out, cal_out;
   wire [1:0] bresp_out, rresp_out;
   wire [31:0] rdata_out;
   integer num_errors = 0, check_count = 0, cal_tg = 0, alm_n = 0, wake_n = 0, c0, w0, i;
   reg cal_q = 0;
   localparam OK = `RTCBK_RESP_OKAY;
   localparam SE = `RTCBK_RESP_SLVERR;
   rtcbk_core i_dut (.*);
   always #5 clk_in = ~clk_in;
   // Counts output toggles and event pulses
   always @(posedge clk_in) begin
      cal_q <= cal_out;
      if (cal_out !== cal_q) cal_tg <= cal_tg + 1;
      if (alarm_event_out === 1'b1) alm_n <= alm_n + 1;
      if (standby_wake_out === 1'b1) wake_n <= wake_n + 1;
   end
   // Write cycle, address and data offered together
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      reg ad, wd;
      begin
         @(posedge clk_in);
         awaddr_in <= a;
         wdata_in <= d;
         awvalid_in <= 1'b1;
         wvalid_in <= 1'b1;
         ad = 0;
         wd = 0;
         while (!(ad && wd)) begin
            @(posedge clk_in);
            if (!ad && awready_out === 1'b1) begin ad = 1; awvalid_in <= 1'b0; end
            if (!wd && wready_out === 1'b1) begin wd = 1; wvalid_in <= 1'b0; end
         end
         while (bvalid_out !== 1'b1) @(posedge clk_in);
         bready_in <= 1'b1;
         @(posedge clk_in);
         `CHK("bresp", er, bresp_out)
         bready_in <= 1'b0;
      end
   endtask
   // Read cycle with a late ready
   task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
      begin
         @(posedge clk_in);
         araddr_in <= a;
         arvalid_in <= 1'b1;
         @(posedge clk_in);
         while (arready_out !== 1'b1) @(posedge clk_in);
         arvalid_in <= 1'b0;
         while (rvalid_out !== 1'b1) @(posedge clk_in);
         rready_in <= 1'b1;
         @(posedge clk_in);
         `CHK("rdata", ed, rdata_out)
         `CHK("rresp", er, rresp_out)
         rready_in <= 1'b0;
      end
   endtask
   // Source pulses; code 3 pulses the crystal line
   task pulse(input [1:0] s, input integer k);
      repeat (k) begin
         @(posedge clk_in);
         xtal_tick_in <= (s == 2'h0) || (s == 2'h3);
         lprc_tick_in <= (s == 2'h1);
         fast_external_clock_tick_in <= (s == 2'h2);
         @(posedge clk_in);
         xtal_tick_in <= 1'b0;
         lprc_tick_in <= 1'b0;
         fast_external_clock_tick_in <= 1'b0;
      end
   endtask
   task conclude;
      begin
         $display("Checks %0d, mismatches %0d", check_count, num_errors);
         if (num_errors == 0 && check_count > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #900000;
      num_errors++;
      conclude;
   end
   initial begin
      repeat (3) @(posedge clk_in);
      external_reset_pin_in <= 1'b1;
      bkp_external_reset_pin_in <= 1'b1;
      rd(8'h00, 32'h0, OK);
      rd(8'h0C, 32'h7FFF, OK);
      rd(8'h10, 32'h7FFF, OK);
      rd(8'h18, 32'hFFFFFFFF, OK);
      rd(8'h1C, 32'h0, SE);
      wr(8'h1C, 32'h1, SE);
      $display("Reset values done");
      for (i = 0; i < 10; i++) wr(8'(8'h20 + 4 * i), {16'hFFFF, 16'(16'h1111 * i)}, OK);
      external_reset_pin_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      external_reset_pin_in <= 1'b1;
      for (i = 0; i < 10; i++) rd(8'(8'h20 + 4 * i), {16'h0, 16'(16'h1111 * i)}, OK);
      rd(8'h48, 32'h0, SE);
      $display("Backup store done");
      wr(8'h0C, 32'h2, OK);
      pulse(2'h0, 32767);
      rd(8'h14, 32'h0, OK);
      pulse(2'h0, 1);
      rd(8'h14, 32'h1, OK);
      rd(8'h04, 32'h1, OK);
      rd(8'h04, 32'h0, OK);
      for (i = 0; i < 4; i++) begin
         wr(8'h00, i, OK);
         wr(8'h14, 32'h0, OK);
         pulse(2'(i), (i == 2) ? 768 : 6);
         rd(8'h14, (i == 3) ? 32'h0 : 32'h2, OK);
      end
      $display("Time base done");
      wr(8'h00, 32'h0, OK);
      wr(8'h08, 32'h2, OK);
      wr(8'h18, 32'h2, OK);
      wr(8'h14, 32'h0, OK);
      standby_in <= 1'b1;
      c0 = alm_n;
      w0 = wake_n;
      pulse(2'h0, 3);
      @(posedge clk_in);
      `CHK("irq masked", 1'b0, irq_out)
      pulse(2'h0, 3);
      repeat (2) @(posedge clk_in);
      `CHK("irq", 1'b1, irq_out)
      `CHK("alarm pulses", 1, alm_n - c0)
      `CHK("wake pulses", 1, wake_n - w0)
      rd(8'h04, 32'h3, OK);
      repeat (2) @(posedge clk_in);
      `CHK("irq cleared", 1'b0, irq_out)
      rd(8'h14, 32'h2, OK);
      clk_en_in <= 1'b0;
      pulse(2'h0, 6);
      clk_en_in <= 1'b1;
      rd(8'h14, 32'h2, OK);
      standby_in <= 1'b0;
      $display("Alarm done");
      wr(8'h00, 32'h4, OK);
      repeat (10) @(posedge clk_in);
      pulse(2'h0, 64);
      c0 = cal_tg;
      pulse(2'h0, 128);
      `CHK("cal toggles", 4, cal_tg - c0)
      pulse(2'h0, 32);
      repeat (10) @(posedge clk_in);
      `CHK("cal high", 1'b1, cal_out)
      wr(8'h00, 32'h0, OK);
      repeat (3) @(posedge clk_in);
      `CHK("cal off", 1'b0, cal_out)
      $display("Calibration done");
      conclude;
   end
endmodule
